// file: core/ibl_pkg.sv
package ibl_pkg;

  // ************************************************************
  // bus and map
  // ************************************************************
  localparam int IBL_AW = 20;
  localparam int IBL_DW = 32;

  // register indices; the byte address is four times the index
  localparam logic [IBL_AW-1:0] IBL_PROGRESS_IDX  = 20'h01D3E;
  localparam logic [IBL_AW-1:0] IBL_CONFIG_IDX    = 20'h1D3BC;
  localparam logic [IBL_AW-1:0] IBL_PROGRESS_ADDR = {IBL_PROGRESS_IDX[IBL_AW-3:0], 2'b00};
  localparam logic [IBL_AW-1:0] IBL_CONFIG_ADDR   = {IBL_CONFIG_IDX[IBL_AW-3:0], 2'b00};

  // ************************************************************
  // field layout (bit numbers count from the word's lsb, bit 0)
  // ************************************************************
  localparam int IBL_CNT_LSB       = 16;
  localparam int IBL_WADDR_LSB     = 0;
  localparam int IBL_BOOTING_BIT   = 31;
  localparam int IBL_BOOT_OFF_BIT  = 30;
  localparam int IBL_ADDR_SIZE_BIT = 29;
  localparam int IBL_PAGE_EN_BIT   = 28;
  localparam int IBL_DEV_LSB       = 0;
  localparam logic [IBL_DW-1:0] IBL_CFG_RSVD_MASK = 32'h0FFFFF80;
  localparam logic [IBL_DW-1:0] IBL_ZERO_WORD     = 32'h00000000;

  // ************************************************************
  // reset values and steps
  // ************************************************************
  localparam logic [15:0] IBL_CNT_RST    = 16'h0000;
  localparam logic [15:0] IBL_WADDR_RST  = 16'h0000;
  localparam logic [6:0]  IBL_DEV_RST    = 7'h00;
  localparam logic [15:0] IBL_CHAIN_MASK = 16'hFFF8;
  localparam logic [15:0] IBL_STEP16     = 16'h0001;
  localparam logic [6:0]  IBL_STEP7      = 7'h01;

  typedef enum logic [0:0] {
    IBL_IDLE   = 1'b0,
    IBL_ACTIVE = 1'b1
  } ibl_phase_t;

  // strobes and data from the loader core
  typedef struct packed {
    logic        boot_start;
    logic        boot_done;
    logic        count_load;
    logic [15:0] count_data;
    logic        pair_done;
    logic        word_step;
    logic        chain;
    logic [15:0] chain_addr;
    logic        ctrl_size;
    logic        ctrl_page_en;
    logic [6:0]  ctrl_dev_addr;
    logic        page_step;
  } ibl_strobe_t;

  // tracked state shown to software
  typedef struct packed {
    logic [15:0] remaining_pairs_count;
    logic [15:0] word_addr;
    logic        booting;
    logic        boot_disable;
    logic        eeprom_address_size;
    logic        page_step_enable;
    logic [6:0]  dev_addr;
  } ibl_view_t;

endpackage

// file: core/ibl_apb_slave.sv
`timescale 1ns/100ps
module ibl_apb_slave
  import ibl_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [IBL_AW-1:0] paddr,
  input  wire ibl_view_t         view,
  output logic [IBL_DW-1:0]      prdata,
  output logic                   pready,
  output logic                   pslverr
);

  // ************************************************************
  // decode
  // ************************************************************
  logic [IBL_DW-1:0] rd_word;
  logic              hit;
  logic [IBL_DW-1:0] prdata_d;
  logic [IBL_DW-1:0] prdata_q;
  logic              hit_d;
  logic              hit_q;

  always_comb begin
    rd_word = IBL_ZERO_WORD;
    hit     = 1'b1;
    case (paddr)
      IBL_PROGRESS_ADDR: begin
        rd_word[IBL_CNT_LSB +: 16]   = view.remaining_pairs_count;
        rd_word[IBL_WADDR_LSB +: 16] = view.word_addr;
      end
      IBL_CONFIG_ADDR: begin
        rd_word[IBL_BOOTING_BIT]   = view.booting;
        rd_word[IBL_BOOT_OFF_BIT]  = view.boot_disable;
        rd_word[IBL_ADDR_SIZE_BIT] = view.eeprom_address_size;
        rd_word[IBL_PAGE_EN_BIT]   = view.page_step_enable;
        rd_word[IBL_DEV_LSB +: 7]  = view.dev_addr;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // read data captured in the setup cycle, writes have no effect
  // ************************************************************
  always_comb begin
    prdata_d = prdata_q;
    hit_d    = hit_q;
    if (psel && !penable) begin
      prdata_d = pwrite ? IBL_ZERO_WORD : rd_word;
      hit_d    = hit;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata_q <= IBL_ZERO_WORD;
      hit_q    <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      hit_q    <= hit_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_q;

endmodule

// file: core/ibl_progress_status.sv
`timescale 1ns/100ps
module ibl_progress_status
  import ibl_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire ibl_strobe_t       ldr,
  input  wire logic              boot_disable,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [IBL_AW-1:0] paddr,
  input  wire logic [IBL_DW-1:0] pwdata,
  output logic [IBL_DW-1:0]      prdata,
  output logic                   pready,
  output logic                   pslverr
);

  // ************************************************************
  // tracked state
  // ************************************************************
  ibl_phase_t  phase_q;
  ibl_phase_t  phase_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [15:0] waddr_q;
  logic [15:0] waddr_d;
  logic        size_q;
  logic        size_d;
  logic        page_q;
  logic        page_d;
  logic [6:0]  dev_q;
  logic [6:0]  dev_d;
  ibl_view_t   view;
  logic        wdata_unused;

  // write data is accepted and dropped
  assign wdata_unused = ^pwdata;

  // ************************************************************
  // boot phase
  // ************************************************************
  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      IBL_IDLE: begin
        if (ldr.boot_start) begin
          phase_d = IBL_ACTIVE;
        end
      end
      IBL_ACTIVE: begin
        if (ldr.boot_done && !ldr.boot_start) begin
          phase_d = IBL_IDLE;
        end
      end
      default: begin
        phase_d = IBL_IDLE;
      end
    endcase
  end

  // ************************************************************
  // counters and captured settings
  // ************************************************************
  always_comb begin
    cnt_d   = cnt_q;
    waddr_d = waddr_q;
    size_d  = size_q;
    page_d  = page_q;
    dev_d   = dev_q;
    // count: a fresh load beats a decrement in the same cycle
    if (ldr.count_load) begin
      cnt_d = ldr.count_data;
    end else if (ldr.pair_done && cnt_q != IBL_CNT_RST) begin
      cnt_d = cnt_q - IBL_STEP16;
    end
    // word address: a chain beats a step
    if (ldr.chain) begin
      waddr_d = ldr.chain_addr & IBL_CHAIN_MASK;
    end else if (ldr.boot_start) begin
      waddr_d = IBL_WADDR_RST;
    end else if (ldr.word_step) begin
      waddr_d = waddr_q + IBL_STEP16;
    end
    // settings latched from the boot control register
    if (ldr.boot_start || ldr.chain) begin
      size_d = ldr.ctrl_size;
      page_d = ldr.ctrl_page_en;
      dev_d  = ldr.ctrl_dev_addr;
    end else if (ldr.page_step && page_q) begin
      dev_d = dev_q + IBL_STEP7;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_q <= IBL_IDLE;
      cnt_q   <= IBL_CNT_RST;
      waddr_q <= IBL_WADDR_RST;
      size_q  <= 1'b0;
      page_q  <= 1'b0;
      dev_q   <= IBL_DEV_RST;
    end else begin
      phase_q <= phase_d;
      cnt_q   <= cnt_d;
      waddr_q <= waddr_d;
      size_q  <= size_d;
      page_q  <= page_d;
      dev_q   <= dev_d;
    end
  end

  // ************************************************************
  // register view and bus slave
  // ************************************************************
  always_comb begin
    view.remaining_pairs_count = cnt_q;
    view.word_addr             = waddr_q;
    view.booting               = (phase_q == IBL_ACTIVE);
    view.boot_disable          = boot_disable;
    view.eeprom_address_size   = size_q;
    view.page_step_enable      = page_q;
    view.dev_addr              = dev_q;
  end

  ibl_apb_slave ibl_apb_slave_inst (
    .clk     (clk),
    .nrst    (nrst),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .view    (view),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence progress_read_s;
    psel && !penable && !pwrite && paddr == IBL_PROGRESS_ADDR ##1 psel && penable;
  endsequence

  sequence config_read_s;
    psel && !penable && !pwrite && paddr == IBL_CONFIG_ADDR ##1 psel && penable;
  endsequence

  sequence bus_write_s;
    psel && !penable && pwrite ##1 psel && penable;
  endsequence

  sequence unmapped_s;
    psel && !penable && paddr != IBL_PROGRESS_ADDR && paddr != IBL_CONFIG_ADDR
      ##1 psel && penable;
  endsequence

  sequence mapped_s;
    psel && !penable && (paddr == IBL_PROGRESS_ADDR || paddr == IBL_CONFIG_ADDR)
      ##1 psel && penable;
  endsequence

  property progress_view_p;
    progress_read_s |-> prdata[IBL_CNT_LSB +: 16] == $past(cnt_q)
      && prdata[IBL_WADDR_LSB +: 16] == $past(waddr_q);
  endproperty

  progress_view_a: assert property (progress_view_p)
    else $error("progress read does not show count and word address");

  count_load_a: assert property (
    ldr.count_load |=> cnt_q == $past(ldr.count_data))
    else $error("pair count not loaded from eeprom bytes");

  count_dec_a: assert property (
    ldr.pair_done && !ldr.count_load && cnt_q != IBL_CNT_RST
      |=> cnt_q == $past(cnt_q) - IBL_STEP16)
    else $error("pair count did not drop by one");

  count_hold_a: assert property (
    !ldr.pair_done && !ldr.count_load |=> $stable(cnt_q))
    else $error("pair count moved without a strobe");

  waddr_step_a: assert property (
    ldr.word_step && !ldr.chain && !ldr.boot_start
      |=> waddr_q == $past(waddr_q) + IBL_STEP16)
    else $error("word address did not increment");

  waddr_chain_a: assert property (
    ldr.chain |=> waddr_q == ($past(ldr.chain_addr) & IBL_CHAIN_MASK)
      && waddr_q[2:0] == 3'h0)
    else $error("chain did not load word address with low bits clear");

  booting_seq_a: assert property (
    ldr.boot_start ##1 (!ldr.boot_done)[*2]
      |-> view.booting && $past(view.booting))
    else $error("booting bit not held while boot runs");

  booting_end_a: assert property (
    ldr.boot_done && !ldr.boot_start |=> !view.booting)
    else $error("booting bit not cleared at boot end");

  size_capture_a: assert property (
    (ldr.boot_start || ldr.chain) |=> size_q == $past(ldr.ctrl_size))
    else $error("address size not captured");

  size_hold_a: assert property (
    !ldr.boot_start && !ldr.chain |=> $stable(size_q))
    else $error("address size changed outside start or chain");

  page_off_a: assert property (
    ldr.page_step && !page_q && !ldr.boot_start && !ldr.chain |=> $stable(dev_q))
    else $error("device address stepped with page increment off");

  dev_step_a: assert property (
    ldr.page_step && page_q && !ldr.boot_start && !ldr.chain
      |=> dev_q == $past(dev_q) + IBL_STEP7)
    else $error("device address did not step");

  config_view_a: assert property (
    config_read_s |-> prdata[IBL_DEV_LSB +: 7] == $past(dev_q)
      && prdata[IBL_BOOTING_BIT] == $past(view.booting)
      && prdata[IBL_PAGE_EN_BIT] == $past(page_q))
    else $error("config read does not show tracked state");

  reserved_zero_a: assert property (
    config_read_s |-> (prdata & IBL_CFG_RSVD_MASK) == IBL_ZERO_WORD)
    else $error("reserved config bits not zero");

  write_ignored_a: assert property (
    bus_write_s and (!ldr.count_load && !ldr.pair_done)[*2]
      |-> cnt_q == $past(cnt_q, 1))
    else $error("bus write disturbed the pair count");

  read_no_effect_a: assert property (
    progress_read_s and (!ldr.count_load && !ldr.pair_done)[*2]
      |-> $stable(cnt_q))
    else $error("bus read disturbed the pair count");

  count_floor_a: assert property (
    ldr.pair_done && !ldr.count_load && cnt_q == IBL_CNT_RST
      |=> cnt_q == IBL_CNT_RST)
    else $error("pair count wrapped below zero");

  waddr_start_a: assert property (
    ldr.boot_start && !ldr.chain |=> waddr_q == IBL_WADDR_RST)
    else $error("word address not cleared at boot start");

  waddr_hold_a: assert property (
    !ldr.word_step && !ldr.chain && !ldr.boot_start |=> $stable(waddr_q))
    else $error("word address moved without a strobe");

  booting_start_a: assert property (
    ldr.boot_start |=> view.booting)
    else $error("booting bit not set at boot start");

  booting_hold_a: assert property (
    !ldr.boot_start && !ldr.boot_done |=> $stable(view.booting))
    else $error("booting bit moved without a strobe");

  config_size_a: assert property (
    config_read_s |-> prdata[IBL_ADDR_SIZE_BIT] == $past(size_q)
      && prdata[IBL_BOOT_OFF_BIT] == $past(boot_disable))
    else $error("config read does not show address size");

  page_capture_a: assert property (
    (ldr.boot_start || ldr.chain) |=> page_q == $past(ldr.ctrl_page_en))
    else $error("page increment setting not captured");

  page_hold_a: assert property (
    !ldr.boot_start && !ldr.chain |=> $stable(page_q))
    else $error("page increment setting changed outside start or chain");

  dev_capture_a: assert property (
    (ldr.boot_start || ldr.chain) |=> dev_q == $past(ldr.ctrl_dev_addr))
    else $error("device address not captured");

  dev_hold_a: assert property (
    !ldr.boot_start && !ldr.chain && !ldr.page_step |=> $stable(dev_q))
    else $error("device address moved without a strobe");

  write_zero_a: assert property (
    bus_write_s |-> prdata == IBL_ZERO_WORD)
    else $error("bus write returned nonzero read data");

  unmapped_err_a: assert property (
    unmapped_s |-> pslverr && prdata == IBL_ZERO_WORD)
    else $error("unmapped access not refused");

  mapped_ok_a: assert property (
    mapped_s |-> !pslverr)
    else $error("mapped access flagged an error");

endmodule

// file: bench/ibl_loader_model.sv
`timescale 1ns/100ps
module ibl_loader_model
  import ibl_pkg::*;
(
  input  wire logic  clk,
  output ibl_strobe_t ldr
);
  initial begin
    ldr = '0;
  end

  // ************************************************************
  // one strobe cycle, data inverted once the pulse is gone
  // ************************************************************
  task automatic fire(input ibl_strobe_t s, input int gap);
    ibl_strobe_t idle;
    idle = '0;
    idle.count_data    = ~s.count_data;
    idle.chain_addr    = ~s.chain_addr;
    idle.ctrl_size     = ~s.ctrl_size;
    idle.ctrl_page_en  = ~s.ctrl_page_en;
    idle.ctrl_dev_addr = ~s.ctrl_dev_addr;
    repeat (gap) @(posedge clk);
    @(posedge clk);
    ldr <= s;
    @(posedge clk);
    ldr <= idle;
  endtask
endmodule

// file: bench/i2c_boot_load_progress_status_tb.sv
`timescale 1ns/100ps
module i2c_boot_load_progress_status_tb
  import ibl_pkg::*;
;
  logic              clk;
  logic              nrst;
  logic              boot_disable;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [IBL_AW-1:0] paddr;
  logic [IBL_DW-1:0] pwdata;
  logic [IBL_DW-1:0] prdata;
  logic              pready;
  logic              pslverr;
  ibl_strobe_t       ldr;
  ibl_strobe_t       st;
  logic [IBL_DW-1:0] rd;
  logic              er;
  int                err_total;
  int                compares;

  always #2 clk = ~clk;

  ibl_loader_model ibl_loader_model_inst (.clk(clk), .ldr(ldr));

  ibl_progress_status ibl_progress_status_inst (
    .clk(clk), .nrst(nrst), .ldr(ldr), .boot_disable(boot_disable),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic complete_run;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic wr, input logic [IBL_AW-1:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [IBL_AW-1:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h00000000);
    check(rd, exp);
    check({31'h00000000, er}, 32'h00000000);
  endtask

  task automatic send(input int gap);
    ibl_loader_model_inst.fire(st, gap);
    st = '0;
  endtask

  function automatic logic [31:0] cfg(logic b, logic d, logic s, logic p, logic [6:0] dv);
    return {b, d, s, p, 21'h000000, dv};
  endfunction

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    rdchk(IBL_PROGRESS_ADDR, 32'h00000000);
    rdchk(IBL_CONFIG_ADDR, 32'h00000000);
    xfer(1'b1, IBL_PROGRESS_ADDR, 32'hFFFFFFFF);
    check({31'h00000000, er}, 32'h00000000);
    rdchk(IBL_PROGRESS_ADDR, 32'h00000000);
    xfer(1'b0, 20'h00010, 32'h00000000);
    check({er, rd[30:0]}, 32'h80000000);
  endtask

  task automatic t_boot;
    st.boot_start    = 1'b1;
    st.ctrl_size     = 1'b1;
    st.ctrl_page_en  = 1'b1;
    st.ctrl_dev_addr = 7'h55;
    send(0);
    rdchk(IBL_CONFIG_ADDR, cfg(1'b1, 1'b0, 1'b1, 1'b1, 7'h55));
    st.count_load = 1'b1;
    st.count_data = {8'h00, 8'h03};
    send(2);
    st.pair_done = 1'b1;
    send(0);
    st.pair_done = 1'b1;
    send(0);
    st.word_step = 1'b1;
    send(0);
    st.word_step = 1'b1;
    send(1);
    rdchk(IBL_PROGRESS_ADDR, {16'h0001, 16'h0002});
    st.pair_done  = 1'b1;
    st.count_load = 1'b1;
    st.count_data = 16'h0100;
    send(0);
    st.page_step = 1'b1;
    send(0);
    rdchk(IBL_PROGRESS_ADDR, {16'h0100, 16'h0002});
    rdchk(IBL_CONFIG_ADDR, cfg(1'b1, 1'b0, 1'b1, 1'b1, 7'h56));
  endtask

  task automatic t_chain;
    boot_disable     <= 1'b1;
    st.chain         = 1'b1;
    st.chain_addr    = 16'h1237;
    st.ctrl_dev_addr = 7'h7F;
    send(0);
    rdchk(IBL_PROGRESS_ADDR, {16'h0100, 16'h1230});
    rdchk(IBL_CONFIG_ADDR, cfg(1'b1, 1'b1, 1'b0, 1'b0, 7'h7F));
    st.page_step = 1'b1;
    send(0);
    st.count_load = 1'b1;
    st.count_data = 16'h0001;
    send(0);
    st.pair_done = 1'b1;
    send(0);
    st.pair_done = 1'b1;
    send(0);
    rdchk(IBL_PROGRESS_ADDR, {16'h0000, 16'h1230});
    rdchk(IBL_CONFIG_ADDR, cfg(1'b1, 1'b1, 1'b0, 1'b0, 7'h7F));
    st.boot_done = 1'b1;
    send(3);
    rdchk(IBL_CONFIG_ADDR, cfg(1'b0, 1'b1, 1'b0, 1'b0, 7'h7F));
    rdchk(IBL_CONFIG_ADDR, cfg(1'b0, 1'b1, 1'b0, 1'b0, 7'h7F));
  endtask

  // busy state, then a reset in mid-run must clear all tracked state; boot_disable stays set
  task automatic t_rerun;
    st.boot_start    = 1'b1;
    st.ctrl_size     = 1'b1;
    st.ctrl_page_en  = 1'b1;
    st.ctrl_dev_addr = 7'h11;
    send(0);
    st.count_load = 1'b1;
    st.count_data = 16'h00A5;
    st.word_step  = 1'b1;
    send(0);
    rdchk(IBL_PROGRESS_ADDR, {16'h00A5, 16'h0001});
    rdchk(IBL_CONFIG_ADDR, cfg(1'b1, 1'b1, 1'b1, 1'b1, 7'h11));
    @(posedge clk);
    nrst <= 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rdchk(IBL_PROGRESS_ADDR, 32'h00000000);
    rdchk(IBL_CONFIG_ADDR, cfg(1'b0, 1'b1, 1'b0, 1'b0, 7'h00));
  endtask

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    clk          = 1'b0;
    nrst         = 1'b0;
    boot_disable = 1'b0;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = '0;
    pwdata       = '0;
    st           = '0;
    err_total    = 0;
    compares     = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_boot();
    t_chain();
    t_rerun();
    complete_run();
  end

  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    complete_run();
  end
endmodule
